// [rtl/astx_regs.vh]
`ifndef ASTX_REGS_VH
`define ASTX_REGS_VH
// Register byte offsets
`define ASTX_TXCS_OFF 12'h000
`define ASTX_RXCS_OFF 12'h004
`define ASTX_BAUDCON_OFF 12'h008
`define ASTX_BAUDDIV_OFF 12'h00C
`define ASTX_TXBUF_OFF 12'h010
`define ASTX_RXDATA_OFF 12'h014
// Transmit control/status fields
`define ASTX_TX_NINTH 0
`define ASTX_TX_SHEMPTY 1
`define ASTX_TX_SYNC 4
`define ASTX_TX_ENABLE 5
`define ASTX_TX_NINE 6
`define ASTX_TX_BUFEMPTY 7
`define ASTX_TX_IRQEN 8
// Receive control/status fields
`define ASTX_RX_NINTH 0
`define ASTX_RX_OVERRUN 1
`define ASTX_RX_FRAMING 2
`define ASTX_RX_ENABLE 4
`define ASTX_RX_NINE 6
`define ASTX_RX_PORTEN 7
`define ASTX_RX_AVAIL 8
// Baud control fields
`define ASTX_BD_WIDE 3
`define ASTX_BD_INVERT 4
`define ASTX_BD_HIGHSPD 5
// Reset values
`define ASTX_BAUDDIV_RST 16'h0000
// Oversampling and frame timing
`define ASTX_OVERSAMPLE 16
`define ASTX_HALF_BIT 8
`define ASTX_VOTE_LO 7
`define ASTX_VOTE_HI 9
`endif

// [rtl/astx_uart.v]
// Operation
// - Idle line rests at mark level
// - Frame is start, 8/9 data, stop
// - Bit lasts one baud period, 8/16-bit divider
// - Data shifted least significant bit first
// - Independent paths and data widths, shared baud, no parity
// - Transmit needs enable, async, port enable
// - Empty shifter loads holding buffer at once
// - Busy shifter: buffer waits for stop bit
// - Frame starts right after shifter load
// - Invert bit flips transmit idle and data
// - Buffer-empty flag set while transmit active, unless character queued behind busy shifter
// - Buffer-empty flag valid second cycle after
// - Buffer-empty flag read-only, ignores irq enable
// - Shifter-empty status read-only, no interrupt
// - Nine-bit mode sends ninth bit as MSB
// - Receiver samples at sixteen times baud
// - Received character enters two-entry FIFO
// - Data register returns oldest FIFO entry
// - Receive needs enable, async, port enable
// - Start rechecked at half bit, else abandon
// - Framing status travels with each character
// - Third character on full FIFO sets overrun
// - Receive-available flag set while receive active and FIFO holds data
`timescale 1ns/1ps
`default_nettype none
`include "astx_regs.vh"
module astx_uart (
  input wire mclk, // System clock, 200 MHz
  input wire reset_n, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire rx_line, // Serial receive line
  output reg tx_line, // Serial transmit line
  output reg tx_oe // Transmit driver enable
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_s1_r; // First stage
  reg rst_n_r; // Released reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg tx_enable_r; // Transmit enable
  reg tx_sync_r; // Synchronous mode select (no sync logic)
  reg tx_nine_bit_mode_r; // Nine-bit transmit
  reg tx_ninth_bit_r; // Ninth transmit bit
  reg tx_irq_enable_r; // Stored only, gates nothing here
  reg rx_enable_r; // Continuous receive enable
  reg rx_nine_r; // Nine-bit receive
  reg port_enable_r; // Port enable
  reg tx_invert_r; // Transmit polarity
  reg baud_wide_r; // 16-bit divider select
  reg baud_high_r; // High speed select
  reg [15:0] baud_divisor_r; // Divider value
  wire tx_active = tx_enable_r & ~tx_sync_r & port_enable_r;
  wire rx_active = rx_enable_r & ~tx_sync_r & port_enable_r;
  wire apb_acc = psel & penable & pready;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `ASTX_TXCS_OFF) || (a == `ASTX_RXCS_OFF) ||
        (a == `ASTX_BAUDCON_OFF) || (a == `ASTX_BAUDDIV_OFF) ||
        (a == `ASTX_TXBUF_OFF) || (a == `ASTX_RXDATA_OFF);
    end
  endfunction

  wire wr_txbuf = apb_wr & (paddr == `ASTX_TXBUF_OFF);
  wire rd_rxdata = apb_rd & (paddr == `ASTX_RXDATA_OFF);

  // Register writes
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_enable_r <= 1'b0;
      tx_sync_r <= 1'b0;
      tx_nine_bit_mode_r <= 1'b0;
      tx_ninth_bit_r <= 1'b0;
      tx_irq_enable_r <= 1'b0;
      rx_enable_r <= 1'b0;
      rx_nine_r <= 1'b0;
      port_enable_r <= 1'b0;
      tx_invert_r <= 1'b0;
      baud_wide_r <= 1'b0;
      baud_high_r <= 1'b0;
      baud_divisor_r <= `ASTX_BAUDDIV_RST;
    end else if (apb_wr) begin
      case (paddr)
        `ASTX_TXCS_OFF: begin
          tx_ninth_bit_r <= pwdata[`ASTX_TX_NINTH];
          tx_sync_r <= pwdata[`ASTX_TX_SYNC];
          tx_enable_r <= pwdata[`ASTX_TX_ENABLE];
          tx_nine_bit_mode_r <= pwdata[`ASTX_TX_NINE];
          tx_irq_enable_r <= pwdata[`ASTX_TX_IRQEN];
        end
        `ASTX_RXCS_OFF: begin
          rx_enable_r <= pwdata[`ASTX_RX_ENABLE];
          rx_nine_r <= pwdata[`ASTX_RX_NINE];
          port_enable_r <= pwdata[`ASTX_RX_PORTEN];
        end
        `ASTX_BAUDCON_OFF: begin
          baud_wide_r <= pwdata[`ASTX_BD_WIDE];
          tx_invert_r <= pwdata[`ASTX_BD_INVERT];
          baud_high_r <= pwdata[`ASTX_BD_HIGHSPD];
        end
        `ASTX_BAUDDIV_OFF: begin
          baud_divisor_r <= pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud generator: one pulse per oversample tick
  // ----------------------------------------------------------------
  reg [15:0] bcnt_r; // Down counter
  reg tick_r; // Oversample tick, 16 per bit
  wire [15:0] div_eff = baud_wide_r ? baud_divisor_r :
    {8'h00, baud_divisor_r[7:0]};
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (!port_enable_r) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (bcnt_r == 16'h0000) begin
      bcnt_r <= div_eff;
      tick_r <= 1'b1;
    end else begin
      bcnt_r <= bcnt_r - 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg [8:0] tx_hold_r; // Holding buffer with ninth bit
  reg tx_full_r; // Holding buffer occupied
  reg [10:0] tx_shift_r; // Start, data, stop bits
  reg [3:0] tx_bits_r; // Bits left in frame
  reg [3:0] tx_os_r; // Ticks within bit
  reg tx_busy_r; // Shifter holds a character
  reg tx_empty_r; // Buffer-empty flag, delayed one cycle
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_hold_r <= 9'h000;
      tx_full_r <= 1'b0;
      tx_shift_r <= 11'h7FF;
      tx_bits_r <= 4'h0;
      tx_os_r <= 4'h0;
      tx_busy_r <= 1'b0;
    end else if (!tx_active) begin
      tx_full_r <= 1'b0;
      tx_busy_r <= 1'b0;
      tx_shift_r <= 11'h7FF;
    end else begin
      if (wr_txbuf) begin
        tx_hold_r <= {tx_ninth_bit_r, pwdata[7:0]};
        tx_full_r <= 1'b1;
      end
      if (!tx_busy_r && tx_full_r && !wr_txbuf) begin
        // Load shifter: stop, data LSB first, start
        tx_shift_r <= tx_nine_bit_mode_r ? {1'b1, tx_hold_r, 1'b0} :
          {2'b11, tx_hold_r[7:0], 1'b0};
        tx_bits_r <= tx_nine_bit_mode_r ? 4'hB : 4'hA;
        tx_os_r <= 4'h0;
        tx_busy_r <= 1'b1;
        tx_full_r <= 1'b0;
      end else if (tx_busy_r && tick_r) begin
        tx_os_r <= tx_os_r + 4'h1;
        if (tx_os_r == 4'hF) begin
          tx_shift_r <= {1'b1, tx_shift_r[10:1]};
          tx_bits_r <= tx_bits_r - 4'h1;
          if (tx_bits_r == 4'h1) begin
            tx_busy_r <= 1'b0;
          end
        end
      end
    end
  end
  // Flag registered one cycle after the buffer updates
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_empty_r <= 1'b0;
    end else begin
      tx_empty_r <= tx_active & ~(tx_full_r & tx_busy_r);
    end
  end
  // Line drive, mark when idle
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_line <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      tx_line <= (tx_busy_r ? tx_shift_r[0] : 1'b1) ^ tx_invert_r;
      tx_oe <= port_enable_r;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA = 3'b100;
  reg [2:0] rx_st_r; // Receive state
  reg [3:0] rx_os_r; // Oversample phase
  reg [3:0] rx_cnt_r; // Bits received
  reg [8:0] rx_shift_r; // Receive shift register
  reg [2:0] rx_vote_r; // Samples around bit centre
  reg rx_prev_r; // Previous line level
  reg [9:0] fifo_r [0:1]; // Ninth bit, data; framing kept apart
  reg fifo_fe_r [0:1]; // Framing status per entry
  reg [1:0] fifo_cnt_r; // Entries held
  reg fifo_rd_r; // Oldest entry index
  reg overrun_r; // Overrun flag
  reg fe_keep_r; // Framing status of oldest entry
  wire rx_bit = (rx_vote_r[2] & rx_vote_r[1]) |
    (rx_vote_r[1] & rx_line) | (rx_vote_r[2] & rx_line);
  wire [3:0] rx_need = rx_nine_r ? 4'hA : 4'h9;
  wire rx_done = (rx_st_r == RX_DATA) && tick_r &&
    (rx_os_r == `ASTX_VOTE_HI) && (rx_cnt_r == rx_need - 4'h1);
  wire pop = rd_rxdata && (fifo_cnt_r != 2'b00);
  wire push = rx_done && !overrun_r && (fifo_cnt_r != 2'b10);
  wire [0:0] wr_idx = fifo_rd_r + fifo_cnt_r[0];
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_st_r <= RX_IDLE;
      rx_os_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_shift_r <= 9'h000;
      rx_vote_r <= 3'b111;
      rx_prev_r <= 1'b1;
    end else if (!rx_active || overrun_r) begin
      rx_st_r <= RX_IDLE;
      rx_prev_r <= 1'b1;
    end else if (tick_r) begin
      rx_prev_r <= rx_line;
      rx_os_r <= rx_os_r + 4'h1;
      if (rx_os_r >= `ASTX_VOTE_LO && rx_os_r <= `ASTX_VOTE_HI) begin
        rx_vote_r <= {rx_line, rx_vote_r[2:1]};
      end
      case (rx_st_r)
        RX_IDLE: begin
          if (rx_prev_r && !rx_line) begin
            rx_st_r <= RX_START;
            rx_os_r <= 4'h1;
          end
        end
        RX_START: begin
          if (rx_os_r == `ASTX_HALF_BIT) begin
            if (rx_line) begin
              rx_st_r <= RX_IDLE;
            end else begin
              rx_st_r <= RX_DATA;
              rx_cnt_r <= 4'h0;
              rx_os_r <= 4'hA; // Skip the window just after centre
            end
          end
        end
        RX_DATA: begin
          if (rx_os_r == `ASTX_VOTE_HI) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r < rx_need - 4'h1) begin
              // Fill from the top so the first bit ends at bit 0
              rx_shift_r <= rx_nine_r ? {rx_bit, rx_shift_r[8:1]} :
                {1'b0, rx_bit, rx_shift_r[7:1]};
            end else begin
              rx_st_r <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end
  // FIFO and overrun
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fifo_r[0] <= 10'h000;
      fifo_r[1] <= 10'h000;
      fifo_fe_r[0] <= 1'b0;
      fifo_fe_r[1] <= 1'b0;
      fifo_cnt_r <= 2'b00;
      fifo_rd_r <= 1'b0;
      overrun_r <= 1'b0;
    end else if (!port_enable_r) begin
      fifo_cnt_r <= 2'b00;
      fifo_fe_r[0] <= 1'b0;
      fifo_fe_r[1] <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (!rx_enable_r) begin
        overrun_r <= 1'b0;
      end else if (rx_done && !overrun_r && fifo_cnt_r == 2'b10) begin
        overrun_r <= 1'b1;
      end
      if (push) begin
        fifo_r[wr_idx] <= {1'b0, rx_shift_r};
        fifo_fe_r[wr_idx] <= ~rx_bit;
      end
      if (pop) begin
        fifo_rd_r <= ~fifo_rd_r;
      end
      fifo_cnt_r <= fifo_cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always @* begin
    fe_keep_r = fifo_fe_r[fifo_rd_r];
  end

  // ----------------------------------------------------------------
  // APB read and ready
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ASTX_TXCS_OFF: prdata <= {23'h000000, tx_irq_enable_r,
            tx_empty_r, tx_nine_bit_mode_r, tx_enable_r, tx_sync_r,
            2'b00, ~tx_busy_r, tx_ninth_bit_r};
          `ASTX_RXCS_OFF: prdata <= {23'h000000,
            rx_active & (fifo_cnt_r != 2'b00), port_enable_r, rx_nine_r,
            1'b0, rx_enable_r, 1'b0, fe_keep_r, overrun_r,
            fifo_r[fifo_rd_r][8]};
          `ASTX_BAUDCON_OFF: prdata <= {26'h0000000, baud_high_r,
            tx_invert_r, baud_wide_r, 3'b000};
          `ASTX_BAUDDIV_OFF: prdata <= {16'h0000, baud_divisor_r};
          `ASTX_RXDATA_OFF: prdata <= {24'h000000,
            fifo_r[fifo_rd_r][7:0]};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // astx_uart
`default_nettype wire

// [tb/astx_uart_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checker of the serial block
// ------
module astx_uart_chk (
  input wire mclk, // Clock
  input wire reset_n, // Reset, active low
  input wire psel, // Select
  input wire penable, // Access phase
  input wire pwrite, // Write
  input wire [11:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire rx_line, // Serial in
  input wire tx_line, // Serial out
  input wire tx_oe // Driver enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Setup cycle and known word addresses
  wire setup = psel && !penable;
  wire mapped = paddr <= 12'h014 && paddr[1:0] == 2'h0;
  wire rxcs_wr = psel && penable && pready && pwrite && paddr == 12'h004;
  logic oe_exp_r; // Last port enable written
  // Remember the written port enable
  always @(posedge mclk) begin
    if (rxcs_wr) oe_exp_r <= pwdata[7];
  end
  a_ready_next:
    assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held");
  a_ready_access:
    assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_err:
    assert property (setup && !mapped |=> pslverr) else $error("not refused");
  a_mapped_ok:
    assert property (setup && mapped |=> !pslverr) else $error("refused");
  a_refused_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
  a_bit_width:
    assert property ($changed(tx_line) |=> $stable(tx_line)[*8])
      else $error("serial bit too short");
  a_oe_follow:
    assert property (rxcs_wr |-> ##2 (tx_oe == oe_exp_r))
      else $error("driver enable wrong");
endmodule // astx_uart_chk
bind astx_uart astx_uart_chk astx_uart_chk_i (.mclk(mclk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .tx_line(tx_line), .tx_oe(tx_oe));
`default_nettype wire

// [tb/astx_remote.sv]
`timescale 1ns/1ps
`default_nettype none
// ------
// Remote serial station
// ------
module astx_remote #(parameter int BIT = 32) (
  input wire logic mclk, // Clock
  input wire logic tx_in, // Line from the block
  input wire logic listen, // Decode frames when high
  input wire logic nine, // Nine data bits
  output logic rx_out // Line to the block
);
  logic [9:0] got_q[$]; // Decoded frames, stop bit on top
  initial rx_out = 1'b1;
  // Send one frame, then two idle bits
  task automatic send(input logic [8:0] d, input logic stp);
    int n;
    n = nine ? 9 : 8;
    for (int i = 0; i < n + 2; i++) begin
      rx_out <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stp;
      repeat (BIT) @(posedge mclk);
    end
    rx_out <= 1'b1;
    repeat (2 * BIT) @(posedge mclk);
  endtask
  // Short low pulse, too brief for a start bit
  task automatic glitch();
    rx_out <= 1'b0;
    repeat (4) @(posedge mclk);
    rx_out <= 1'b1;
    repeat (2 * BIT) @(posedge mclk);
  endtask
  // Decode frames from the block at bit centres
  initial forever begin : decode
    logic [9:0] v;
    @(negedge tx_in);
    repeat (BIT / 2) @(posedge mclk);
    if (listen && !tx_in) begin
      v = 10'h000;
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (BIT) @(posedge mclk);
        v[i] = tx_in;
      end
      got_q.push_back(v);
    end
  end
endmodule // astx_remote
`default_nettype wire

// [tb/tb_async_serial_txrx.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_txrx;
  localparam int BIT = 32; // Divisor 1: 2 clocks a tick, 16 ticks
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic listen = 1'b1;
  logic nine = 1'b0;
  logic [31:0] q; // Last read data
  logic e; // Last error
  int err_total = 0;
  int checks_done = 0;
  wire [31:0] prdata;
  wire pready, pslverr, rx_line, tx_line, tx_oe;
  always #2.5 mclk = ~mclk;
  astx_uart astx_uart_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .tx_line(tx_line), .tx_oe(tx_oe));
  astx_remote #(.BIT(BIT)) astx_remote_i (.mclk(mclk), .tx_in(tx_line),
    .listen(listen), .nine(nine), .rx_out(rx_line));
  // ------
  // Shared tasks
  // ------
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // One bus transfer, held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
    input string n);
    apb(1'b0, a, 32'h0);
    chk(n, x, q & m);
  endtask
  task wait_frames(input int n);
    int k;
    k = 0;
    while (astx_remote_i.got_q.size() < n && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    chk("frame count", n, astx_remote_i.got_q.size());
  endtask
  // ------
  // Scenarios
  // ------
  task t_regs;
    rd(12'h000, 32'hFFFFFFFF, 32'h2, "txcs reset");
    rd(12'h00C, 32'hFFFFFFFF, 32'h0, "divisor reset");
    apb(1'b1, 12'h00C, 32'h101);
    rd(12'h00C, 32'hFFFF, 32'h101, "divisor");
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask
  task t_tx;
    apb(1'b1, 12'h004, 32'h90);
    apb(1'b1, 12'h000, 32'h20);
    chk("driver on", 32'h1, {31'h0, tx_oe});
    rd(12'h000, 32'h82, 32'h82, "tx idle");
    apb(1'b1, 12'h010, 32'hA5);
    apb(1'b1, 12'h010, 32'h3C);
    repeat (2) @(posedge mclk);
    rd(12'h000, 32'h82, 32'h0, "tx queued");
    wait_frames(2);
    repeat (BIT) @(posedge mclk);
    rd(12'h000, 32'h82, 32'h82, "tx drained");
    chk("frame a", 32'h1A5, astx_remote_i.got_q.pop_front());
    chk("frame b", 32'h13C, astx_remote_i.got_q.pop_front());
    nine = 1'b1;
    apb(1'b1, 12'h000, 32'h161);
    apb(1'b1, 12'h010, 32'h55);
    rd(12'h000, 32'h180, 32'h180, "flag with irq on");
    apb(1'b1, 12'h000, 32'h61);
    wait_frames(1);
    chk("frame nine", 32'h355, astx_remote_i.got_q.pop_front());
    nine = 1'b0;
    apb(1'b1, 12'h000, 32'h30);
    rd(12'h000, 32'h80, 32'h0, "sync blocks tx");
    apb(1'b1, 12'h000, 32'h20);
  endtask
  task t_rx;
    astx_remote_i.send(9'h096, 1'b1);
    astx_remote_i.send(9'h00F, 1'b0);
    rd(12'h004, 32'h107, 32'h100, "rx first");
    rd(12'h014, 32'hFF, 32'h96, "rx data a");
    rd(12'h004, 32'h107, 32'h104, "rx second");
    rd(12'h014, 32'hFF, 32'h0F, "rx data b");
    rd(12'h004, 32'h100, 32'h0, "rx empty");
    astx_remote_i.glitch();
    astx_remote_i.send(9'h05A, 1'b1);
    rd(12'h014, 32'hFF, 32'h5A, "after glitch");
    rd(12'h004, 32'h100, 32'h0, "glitch ignored");
    astx_remote_i.send(9'h011, 1'b1);
    astx_remote_i.send(9'h022, 1'b1);
    astx_remote_i.send(9'h033, 1'b1);
    rd(12'h004, 32'h102, 32'h102, "overrun");
    rd(12'h014, 32'hFF, 32'h11, "oldest");
    rd(12'h014, 32'hFF, 32'h22, "second");
    astx_remote_i.send(9'h044, 1'b1);
    rd(12'h004, 32'h102, 32'h2, "blocked");
    apb(1'b1, 12'h004, 32'h80);
    apb(1'b1, 12'h004, 32'h90);
    rd(12'h004, 32'h2, 32'h0, "overrun cleared");
    nine = 1'b1;
    apb(1'b1, 12'h004, 32'hD0);
    astx_remote_i.send(9'h1A7, 1'b1);
    rd(12'h004, 32'h101, 32'h101, "rx ninth");
    rd(12'h014, 32'hFF, 32'hA7, "rx nine data");
    nine = 1'b0;
    apb(1'b1, 12'h004, 32'h90);
  endtask
  task t_inv;
    listen = 1'b0;
    apb(1'b1, 12'h008, 32'h10);
    repeat (12) @(posedge mclk);
    chk("idle inverted", 32'h0, {31'h0, tx_line});
    apb(1'b1, 12'h008, 32'h0);
    repeat (12) @(posedge mclk);
    chk("idle mark", 32'h1, {31'h0, tx_line});
    listen = 1'b1;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs;
    t_tx;
    t_rx;
    t_inv;
    stop_test;
  end
  // Watchdog, well past the expected run
  initial begin
    #(5 * 60000);
    err_total++;
    stop_test;
  end
endmodule // tb_async_serial_txrx
`default_nettype wire
